/* src/tcm_map.svh */
// Register indices, field positions and reset values of the timer control block
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
`define TCM_IDX_CTRLA       4'h0
`define TCM_IDX_MODE_CTL    4'h1
`define TCM_IDX_EV_CTL      4'h4
`define TCM_IDX_INT_EN      4'h5
`define TCM_IDX_FLAGS       4'h6
`define TCM_IDX_STATUS      4'h7
`define TCM_IDX_CNT         4'hA
`define TCM_IDX_CAPCMP      4'hC
`define TCM_CTRLA_ENABLE    0
`define TCM_MODE_MSB        2
`define TCM_MODE_LSB        0
`define TCM_OUT_EN_BIT      4
`define TCM_OUT_INIT_BIT    5
`define TCM_EV_INPUT_EN     0
`define TCM_EV_EDGE         4
`define TCM_EV_FILTER       6
`define TCM_INT_CAPTURE     0
`define TCM_STATUS_RUN      0
`define TCM_RST_BIT         1'h0
`define TCM_RST_MODE        3'h0
`define TCM_RST_WORD        16'h0000
`define TCM_RST_RDATA       32'h0000_0000
`define TCM_FILTER_LEN      4
`endif

/* src/tcm_pkg.sv */
// Types shared by the timer control block
package tcm_pkg;
  typedef enum logic [2:0] {
    TCM_PERIODIC = 3'b000,
    TCM_TIMEOUT  = 3'b001,
    TCM_CAPTURE  = 3'b010,
    TCM_FREQ     = 3'b011,
    TCM_PWIDTH   = 3'b100,
    TCM_FREQ_PW  = 3'b101,
    TCM_SHOT     = 3'b110,
    TCM_PWM8     = 3'b111
  } tcm_mode_t;

  typedef enum logic [1:0] {
    TCM_FP_IDLE  = 2'b00,
    TCM_FP_FIRST = 2'b01,
    TCM_FP_SECOND = 2'b10
  } tcm_fpw_t;

  typedef struct packed {
    logic       go;
    logic [3:0] idx;
  } tcm_access_t;
endpackage

/* src/tcm_top.sv */
// Timer mode control, event handling, capture flag and register slave
// Functional notes
// - Output pin idles at the initial-level bit value before operation, but low in eight-bit PWM mode.
// - Output enable clear forces output to zero; set passes mode waveform.
// - Three-bit mode field selects one of eight timer modes.
// - Filter bit routes event input through noise canceller, else bypass.
// - Periodic and eight-bit PWM modes ignore both event edges.
// - Time-out mode: selected edge starts counter, opposite edge stops it.
// - Capture mode: selected edge copies counter to capture register, raises flag.
// - Frequency mode: selected edge captures, clears and restarts counter, raises flag.
// - Pulse-width mode: one edge restarts counter, opposite edge captures and flags.
// - Combined mode: first start edge restarts, following opposite edge captures.
// - Combined mode: second start edge stops counter and sets flag.
// - Single shot: edge-select 0 starts on rise, 1 on either edge.
// - Events act only while event input enable is set.
// - Capture interrupt enable gates flag onto interrupt request.
// - Flag clears on write one, or capture read in capture modes.
// - Periodic and time-out modes set flag when counter reaches top.
// - Single shot sets flag when running counter reaches top.
// - Eight-bit PWM sets flag when counter reaches compare low byte.
// - Read-only run bit shows counter running; no write can set it.
// - Noise canceller passes change only when four samples agree.
// - Every flag-setting condition pulses the event output one cycle.
// - Interrupt stays high while flag and enable both set.
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        ev_in,
  output logic             event_out,
  output logic             cc_out,
  output logic             cc_out_en,
  output logic             irq
);
  tcm_pkg::tcm_access_t wr_ph;
  tcm_pkg::tcm_access_t rd_ph;
  tcm_pkg::tcm_mode_t   mode;
  tcm_pkg::tcm_fpw_t    phase;
  tcm_pkg::tcm_fpw_t    next_phase;
  logic                 enable;
  logic                 out_init;
  logic                 out_en;
  logic                 ev_en;
  logic                 edge_sel;
  logic                 filt_en;
  logic                 cap_ie;
  logic                 cap_flag;
  logic                 run;
  logic                 next_run;
  logic [15:0]          cnt;
  logic [15:0]          cap_cmp;
  logic                 ev_s1;
  logic                 ev_s2;
  logic [3:0]           hist;
  logic                 filt_lvl;
  logic                 ev_lvl;
  logic                 ev_prev;
  logic                 rise;
  logic                 fall;
  logic                 start_edge;
  logic                 stop_edge;
  logic                 top_hit;
  logic                 pwm_hit;
  logic                 do_cap;
  logic                 do_clr;
  logic                 set_flag;
  logic                 next_wave;
  logic                 cnt_wr;
  logic                 cap_cmp_wr;
  logic                 flag_clr;
  logic                 cap_read;
  logic                 take;

  function automatic logic wr_hit(input tcm_pkg::tcm_access_t a, input logic [3:0] idx);
    wr_hit = a.go && (a.idx == idx);
  endfunction

  function automatic logic is_capture_mode(input tcm_pkg::tcm_mode_t m);
    is_capture_mode = (m == tcm_pkg::TCM_CAPTURE) || (m == tcm_pkg::TCM_FREQ) ||
                      (m == tcm_pkg::TCM_PWIDTH) || (m == tcm_pkg::TCM_FREQ_PW);
  endfunction

  // Reads take one wait state so that a write just before is already stored
  assign take      = hsel && htrans[1] && hready;
  assign hreadyout = !rd_ph.go;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph <= '0;
      rd_ph <= '0;
    end
    else
    begin
      wr_ph.go  <= take && hwrite && (haddr[1:0] == 2'b00);
      wr_ph.idx <= haddr[5:2];
      rd_ph.go  <= take && !hwrite;
      rd_ph.idx <= haddr[5:2];
    end
  end

  assign cnt_wr   = wr_hit(wr_ph, `TCM_IDX_CNT);
  assign cap_cmp_wr = wr_hit(wr_ph, `TCM_IDX_CAPCMP);
  assign flag_clr = wr_hit(wr_ph, `TCM_IDX_FLAGS) && hwdata[`TCM_INT_CAPTURE];
  assign cap_read = wr_hit(rd_ph, `TCM_IDX_CAPCMP) && is_capture_mode(mode);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable   <= `TCM_RST_BIT;
      mode     <= tcm_pkg::tcm_mode_t'(`TCM_RST_MODE);
      out_init <= `TCM_RST_BIT;
      out_en   <= `TCM_RST_BIT;
      ev_en    <= `TCM_RST_BIT;
      edge_sel <= `TCM_RST_BIT;
      filt_en  <= `TCM_RST_BIT;
      cap_ie   <= `TCM_RST_BIT;
    end
    else
    begin
      if (wr_hit(wr_ph, `TCM_IDX_CTRLA))
        enable <= hwdata[`TCM_CTRLA_ENABLE];
      if (wr_hit(wr_ph, `TCM_IDX_MODE_CTL))
      begin
        mode     <= tcm_pkg::tcm_mode_t'(hwdata[`TCM_MODE_MSB:`TCM_MODE_LSB]);
        out_en   <= hwdata[`TCM_OUT_EN_BIT];
        out_init <= hwdata[`TCM_OUT_INIT_BIT];
      end
      if (wr_hit(wr_ph, `TCM_IDX_EV_CTL))
      begin
        ev_en    <= hwdata[`TCM_EV_INPUT_EN];
        edge_sel <= hwdata[`TCM_EV_EDGE];
        filt_en  <= hwdata[`TCM_EV_FILTER];
      end
      if (wr_hit(wr_ph, `TCM_IDX_INT_EN))
        cap_ie <= hwdata[`TCM_INT_CAPTURE];
    end
  end

  // Event pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
    end
    else
    begin
      ev_s1 <= ev_in;
      ev_s2 <= ev_s1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hist     <= 4'h0;
      filt_lvl <= 1'b0;
      ev_prev  <= 1'b0;
    end
    else
    begin
      hist    <= {hist[2:0], ev_s2};
      ev_prev <= ev_lvl;
      if (hist == {`TCM_FILTER_LEN{1'b1}} || hist == {`TCM_FILTER_LEN{1'b0}})
        filt_lvl <= hist[0];
    end
  end

  assign ev_lvl = filt_en ? filt_lvl : ev_s2;
  assign rise       = ev_en && enable && ev_lvl && !ev_prev;
  assign fall       = ev_en && enable && !ev_lvl && ev_prev;
  assign start_edge = edge_sel ? fall : rise;
  assign stop_edge  = edge_sel ? rise : fall;
  assign top_hit    = run && (cnt == cap_cmp);
  assign pwm_hit    = run && (cnt[7:0] == cap_cmp[7:0]);

  always_comb
  begin
    next_run   = run;
    next_phase = phase;
    do_cap     = 1'b0;
    do_clr     = 1'b0;
    set_flag   = 1'b0;
    if (!enable)
    begin
      next_run   = 1'b0;
      next_phase = tcm_pkg::TCM_FP_IDLE;
    end
    else
    begin
      case (mode)
        tcm_pkg::TCM_PERIODIC:
        begin
          next_run = 1'b1;
          set_flag = top_hit;
        end
        tcm_pkg::TCM_TIMEOUT:
        begin
          if (start_edge)
            next_run = 1'b1;
          else if (stop_edge)
            next_run = 1'b0;
          set_flag = top_hit;
        end
        tcm_pkg::TCM_CAPTURE:
        begin
          next_run = 1'b1;
          do_cap   = start_edge;
          set_flag = start_edge;
        end
        tcm_pkg::TCM_FREQ:
        begin
          next_run = 1'b1;
          do_cap   = start_edge;
          do_clr   = start_edge;
          set_flag = start_edge;
        end
        tcm_pkg::TCM_PWIDTH:
        begin
          next_run = 1'b1;
          do_clr   = start_edge;
          do_cap   = stop_edge;
          set_flag = stop_edge;
        end
        tcm_pkg::TCM_FREQ_PW:
        begin
          case (phase)
            tcm_pkg::TCM_FP_IDLE:
            begin
              if (start_edge)
              begin
                do_clr     = 1'b1;
                next_run   = 1'b1;
                next_phase = tcm_pkg::TCM_FP_FIRST;
              end
            end
            tcm_pkg::TCM_FP_FIRST:
            begin
              if (stop_edge)
              begin
                do_cap     = 1'b1;
                next_phase = tcm_pkg::TCM_FP_SECOND;
              end
            end
            tcm_pkg::TCM_FP_SECOND:
            begin
              if (start_edge)
              begin
                next_run   = 1'b0;
                set_flag   = 1'b1;
                next_phase = tcm_pkg::TCM_FP_IDLE;
              end
            end
            default:
              next_phase = tcm_pkg::TCM_FP_IDLE;
          endcase
        end
        tcm_pkg::TCM_SHOT:
        begin
          if (!run && (rise || (edge_sel && fall)))
            next_run = 1'b1;
          if (top_hit)
          begin
            next_run = 1'b0;
            set_flag = 1'b1;
          end
        end
        tcm_pkg::TCM_PWM8:
        begin
          next_run = 1'b1;
          set_flag = pwm_hit;
        end
        default:
          next_run = 1'b0;
      endcase
    end
  end

  // Bus writes to the counter win over counting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt   <= `TCM_RST_WORD;
      run   <= `TCM_RST_BIT;
      phase <= tcm_pkg::TCM_FP_IDLE;
    end
    else
    begin
      run   <= next_run;
      phase <= next_phase;
      if (cnt_wr)
        cnt <= hwdata[15:0];
      else if (do_clr)
        cnt <= `TCM_RST_WORD;
      else if (run)
      begin
        if (mode == tcm_pkg::TCM_PWM8)
          cnt <= {8'h00, pwm_hit ? 8'h00 : cnt[7:0] + 8'h01};
        else if (top_hit && (mode == tcm_pkg::TCM_PERIODIC || mode == tcm_pkg::TCM_TIMEOUT ||
                 mode == tcm_pkg::TCM_SHOT))
          cnt <= `TCM_RST_WORD;
        else
          cnt <= cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap_cmp <= `TCM_RST_WORD;
    else if (cap_cmp_wr)
      cap_cmp <= hwdata[15:0];
    else if (do_cap)
      cap_cmp <= cnt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap_flag <= `TCM_RST_BIT;
    else if (set_flag)
      cap_flag <= 1'b1;
    else if (flag_clr || cap_read)
      cap_flag <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      event_out <= 1'b0;
    else
      event_out <= set_flag;
  end

  assign irq = cap_flag && cap_ie;

  // initial level unless shot or PWM drive the pin
  always_comb
  begin
    case (mode)
      tcm_pkg::TCM_SHOT: next_wave = next_run ? !out_init : out_init;
      tcm_pkg::TCM_PWM8: next_wave = run && (cnt[7:0] < cap_cmp[15:8]);
      default:           next_wave = out_init;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cc_out    <= 1'b0;
      cc_out_en <= 1'b0;
    end
    else
    begin
      cc_out    <= out_en ? next_wave : 1'b0;
      cc_out_en <= out_en;
    end
  end

  // run bit read only; unused bits read zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= `TCM_RST_RDATA;
    else if (rd_ph.go)
    begin
      case (rd_ph.idx)
        `TCM_IDX_CTRLA:    hrdata <= {31'h0, enable};
        `TCM_IDX_MODE_CTL: hrdata <= {26'h0, out_init, out_en, 1'b0, mode};
        `TCM_IDX_EV_CTL:   hrdata <= {25'h0, filt_en, 1'b0, edge_sel, 3'h0, ev_en};
        `TCM_IDX_INT_EN:   hrdata <= {31'h0, cap_ie};
        `TCM_IDX_FLAGS:    hrdata <= {31'h0, cap_flag};
        `TCM_IDX_STATUS:   hrdata <= {31'h0, run};
        `TCM_IDX_CNT:      hrdata <= {16'h0, cnt};
        `TCM_IDX_CAPCMP:   hrdata <= {16'h0, cap_cmp};
        default:           hrdata <= `TCM_RST_RDATA;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_out_forced_low: assert property (!out_en |=> !cc_out)
    else $error("output not zero while disabled");
  a_init_level_idle: assert property (out_en && mode == tcm_pkg::TCM_PERIODIC |=> cc_out == $past(out_init))
    else $error("output not at initial level");
  a_periodic_no_capture: assert property ((mode == tcm_pkg::TCM_PERIODIC || mode == tcm_pkg::TCM_PWM8)
    && !cap_cmp_wr |=> $stable(cap_cmp))
    else $error("edge acted in edge-free mode");
  a_capture_copy: assert property (mode == tcm_pkg::TCM_CAPTURE && start_edge && !cap_cmp_wr
    |=> cap_cmp == $past(cnt) && cap_flag)
    else $error("capture did not copy counter");
  a_freq_restart: assert property (mode == tcm_pkg::TCM_FREQ && start_edge && !cnt_wr |=> cnt == 16'h0000)
    else $error("frequency edge did not restart");
  a_events_gated: assert property (!ev_en && mode == tcm_pkg::TCM_TIMEOUT && enable |=> run == $past(run))
    else $error("event acted while disabled");
  a_filter_agree: assert property (filt_en && $changed(filt_lvl) |-> $past(hist) == 4'hF || $past(hist) == 4'h0)
    else $error("filter passed unstable input");
  a_w1c_clears: assert property (flag_clr && !set_flag |=> !cap_flag)
    else $error("write one did not clear flag");
  a_shot_top_stop: assert property (mode == tcm_pkg::TCM_SHOT && top_hit && enable |=> !run && cap_flag)
    else $error("single shot did not stop at top");
  a_evout_with_flag: assert property (event_out |-> cap_flag)
    else $error("event strobe without flag");
  a_irq_drop: assert property ($fell(cap_flag) |-> !irq)
    else $error("interrupt stayed after flag clear");
  a_status_read: assert property (rd_ph.go && rd_ph.idx == `TCM_IDX_STATUS |=> hrdata == {31'h0, $past(run)})
    else $error("status read wrong run bit");

  c_capture_seen: cover property (mode == tcm_pkg::TCM_CAPTURE && do_cap);
  c_fpw_stop: cover property (mode == tcm_pkg::TCM_FREQ_PW && phase == tcm_pkg::TCM_FP_SECOND && start_edge);
  c_shot_done: cover property (mode == tcm_pkg::TCM_SHOT && $fell(run));
  c_set_and_clear: cover property (set_flag && flag_clr);
endmodule // tcm_top

/* sim/tcm_ev_src.sv */
// Event channel model that drives the block's event input
`timescale 1ns/1ps

module tcm_ev_src (
  input  wire logic hclk,
  output logic      ev
);
  initial ev = 1'b0;

  // Idle channel rests low; each level is held whole cycles so the sync stage sees it
  task automatic pulse(input int hi, input int lo);
    @(posedge hclk);
    ev <= 1'b1;
    repeat (hi) @(posedge hclk);
    ev <= 1'b0;
    repeat (lo) @(posedge hclk);
  endtask
endmodule // tcm_ev_src

/* sim/tcm_top_tb_top.sv */
// Self-checking bench for the timer control block
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_top_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, rd_ph;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, ev_in, event_out, cc_out, cc_out_en, irq;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [3:0]  regs [6];
  int          fails, num_checks, ev_cnt, n, x1, x2, xc;
  assign hready = hreadyout;

  tcm_top u_tcm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ev_in(ev_in), .event_out(event_out), .cc_out(cc_out),
    .cc_out_en(cc_out_en), .irq(irq));
  tcm_ev_src u_tcm_ev_src (.hclk(hclk), .ev(ev_in));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= 32'(idx) << 2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph  <= ~wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x});
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic setup(input logic [2:0] m, input logic [31:0] evc, input logic [31:0] top);
    wr(`TCM_IDX_CTRLA, 32'h0000_0000);
    wr(`TCM_IDX_CNT, 32'h0000_0000);
    wr(`TCM_IDX_CAPCMP, top);
    wr(`TCM_IDX_MODE_CTL, 32'(m));
    wr(`TCM_IDX_EV_CTL, evc);
    wr(`TCM_IDX_FLAGS, 32'h0000_0001);
    wr(`TCM_IDX_CTRLA, 32'h0000_0001);
    n = ev_cnt;
  endtask

  // Read results are compared against the oldest note as the data phase ends
  always @(posedge hclk)
  begin
    if (event_out === 1'b1)
      ev_cnt++;
    if (rd_ph === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk("read data", e[31:0], hrdata & e[63:32]);
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
    end
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    fails++;
    $display("watchdog expired");
    print_verdict;
  end

  initial
  begin
    {hresetn, hsel, hwrite, rd_ph, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    fails = 0;
    num_checks = 0;
    ev_cnt = 0;
    regs = '{`TCM_IDX_EV_CTL, `TCM_IDX_INT_EN, `TCM_IDX_FLAGS, `TCM_IDX_STATUS, `TCM_IDX_MODE_CTL, 4'h3};
    void'($urandom(47171));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;

    foreach (regs[i]) rd(regs[i], 32'h0000_0000, 32'hFFFF_FFFF);
    r = $urandom;
    wr(`TCM_IDX_EV_CTL, r);
    rd(`TCM_IDX_EV_CTL, r & 32'h0000_0051, 32'hFFFF_FFFF);
    wr(`TCM_IDX_CAPCMP, r);
    rd(`TCM_IDX_CAPCMP, r & 32'h0000_FFFF, 32'hFFFF_FFFF);
    wr(`TCM_IDX_MODE_CTL, 32'hFFFF_FFFF);
    rd(`TCM_IDX_MODE_CTL, 32'h0000_0037, 32'hFFFF_FFFF);
    wr(`TCM_IDX_STATUS, 32'hFFFF_FFFF);
    rd(`TCM_IDX_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(4'h3, 32'hFFFF_FFFF);
    rd(4'h3, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test registers done");

    for (int i = 0; i < 4; i++)
    begin
      wr(`TCM_IDX_MODE_CTL, {26'h000_0000, i[1:0], 4'h0});
      repeat (2) @(posedge hclk);
      chk("cc_out", {31'h0, i[1] & i[0]}, {31'h0, cc_out});
      chk("cc_out_en", {31'h0, i[0]}, {31'h0, cc_out_en});
    end
    $display("test output level done");

    // Two pulses per mode and edge; flag, run state and event strobes follow the mode table
    for (int m = 0; m < 8; m++)
    begin
      for (int ed = 0; ed < 2; ed++)
      begin
        setup(3'(m), 32'h0000_0001 | (32'(ed) << 4), 32'h0000_FFFF);
        x1 = (m >= 2 && m <= 4) ? 1 : 0;
        x2 = (m >= 2 && m <= 5) ? 1 : 0;
        xc = (m >= 2 && m <= 4) ? 2 : x2;
        u_tcm_ev_src.pulse(3, 6);
        rd(`TCM_IDX_FLAGS, 32'(x1), 32'hFFFF_FFFF);
        u_tcm_ev_src.pulse(3, 6);
        rd(`TCM_IDX_FLAGS, 32'(x2), 32'hFFFF_FFFF);
        rd(`TCM_IDX_STATUS, 32'(!(m == 5 || (m == 1 && ed == 0))), 32'hFFFF_FFFF);
        chk("event strobes", 32'(xc), 32'(ev_cnt - n));
      end
    end
    $display("test mode table done");

    setup(3'h2, 32'h0000_0000, 32'h0000_FFFF);
    u_tcm_ev_src.pulse(3, 6);
    rd(`TCM_IDX_FLAGS, 32'h0000_0000, 32'hFFFF_FFFF);
    setup(3'h2, 32'h0000_0041, 32'h0000_FFFF);
    u_tcm_ev_src.pulse(2, 12);
    rd(`TCM_IDX_FLAGS, 32'h0000_0000, 32'hFFFF_FFFF);
    u_tcm_ev_src.pulse(8, 12);
    rd(`TCM_IDX_FLAGS, 32'h0000_0001, 32'hFFFF_FFFF);
    $display("test filter done");

    wr(`TCM_IDX_INT_EN, 32'h0000_0001);
    @(posedge hclk);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(`TCM_IDX_INT_EN, 32'h0000_0000);
    @(posedge hclk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    wr(`TCM_IDX_INT_EN, 32'h0000_0001);
    wr(`TCM_IDX_FLAGS, 32'h0000_0000);
    rd(`TCM_IDX_FLAGS, 32'h0000_0001, 32'hFFFF_FFFF);
    rd(`TCM_IDX_CAPCMP, 32'h0000_0000, 32'h0000_0000);
    rd(`TCM_IDX_FLAGS, 32'h0000_0000, 32'hFFFF_FFFF);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    u_tcm_ev_src.pulse(3, 6);
    wr(`TCM_IDX_FLAGS, 32'h0000_0001);
    rd(`TCM_IDX_FLAGS, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test flag clear done");

    // Small top values so the compare match comes quickly
    for (int m = 0; m < 8; m += 7)
    begin
      setup(3'(m), 32'h0000_0000, 32'h0000_0008);
      repeat (30) @(posedge hclk);
      rd(`TCM_IDX_FLAGS, 32'h0000_0001, 32'hFFFF_FFFF);
      chk("top strobe", 32'h0000_0001, 32'(ev_cnt != n));
    end
    $display("test top match done");
    @(posedge hclk);
    print_verdict;
  end
endmodule // tcm_top_tb_top
